// ===== include/rstctl_regs.svh
`ifndef RSTCTL_REGS_SVH
`define RSTCTL_REGS_SVH

// register byte offsets on the avalon slave
`define RC_OFF_COMMAND    4'h0
`define RC_OFF_STATUS     4'h4
`define RC_OFF_CONFIG     4'h8

// password field shared by command and config writes
`define RC_KEY_MSB        31
`define RC_KEY_LSB        24
`define RC_KEY_VALUE      8'ha5

// command register bits
`define RC_CMD_CPU_BIT    0
`define RC_CMD_PER_BIT    2
`define RC_CMD_PIN_BIT    3

// status register fields
`define RC_ST_FALL_BIT    0
`define RC_ST_CAUSE_LSB   8
`define RC_ST_LEVEL_BIT   16
`define RC_ST_BUSY_BIT    17

// config register fields
`define RC_CFG_RSTEN_BIT  0
`define RC_CFG_IRQEN_BIT  4
`define RC_CFG_LEN_LSB    8
`define RC_CFG_RESET      32'h00000001

// last reset cause encodings
`define RC_CAUSE_GENERAL  3'h0
`define RC_CAUSE_WDOG     3'h2
`define RC_CAUSE_SOFT     3'h3
`define RC_CAUSE_USER     3'h4

// duration of watchdog, software and user startup phases, core_clk cycles
`define RC_HOLD_CYCLES    3
// general reset pulse: 2^(0+1) cycles with the default length field
`define RC_GEN_PULSE      17'h00002

`endif

// ===== include/rstctl_pkg.sv
package rstctl_pkg;

  // reset state manager states
  typedef enum logic [2:0] {
    ST_GENERAL,
    ST_RUN,
    ST_WDOG,
    ST_SOFT,
    ST_USER
  } rst_state_t;

  // last reset cause field
  typedef logic [2:0] cause_t;

endpackage : rstctl_pkg

// ===== hw/system_reset_controller.sv
`include "rstctl_regs.svh"

// Overview of operation
// - drive cpu, peripheral and pin resets, low active
// - low synchronized pin requests user reset if enabled
// - pin level readable; fall flag cleared by status read
// - irq enable turns pin event into interrupt
// - pin pulse lasts 2^(length+1) cycles
// - config survives all resets except general
// - last cause updated at cpu reset release
// - general reset clears config, pin rises two cycles later
// - watchdog reset lasts three cycles
// - watchdog selector picks cpu only or full reset
// - disabled watchdog reset ignores faults
// - command bits reset cpu, peripherals or pulse pin
// - any command bit starts three cycle software reset
// - command resets assert at write, release synchronously
// - own command pin pulse never seen as user
// - software cause recorded only with cpu bit
// - busy flag blocks command writes until done
// - enabled low pin enters user reset immediately
// - user reset ends three cycles after pin high
// - pin held low keeps internal resets asserted
// - priority general, watchdog, software, user
// - cause codes 0,2,3,4, rest reserved
// - writes need key 0xa5 else dropped
module system_reset_controller #(
  parameter int HOLD_CYCLES = `RC_HOLD_CYCLES  // cycles of a timed reset phase
) (
  // clock and supply reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // watchdog side
  input  wire logic        wdog_fault,
  input  wire logic        wdog_fault_reset_enable,
  input  wire logic        wdog_cpu_only,
  // reset outputs
  output logic             proc_nrst,
  output logic             periph_nrst,
  // external reset pin, open drain
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe,
  // pin event interrupt
  output logic             pin_irq
);

  // elaboration check: hold counter is 8 bits wide
  if (HOLD_CYCLES < 1 || HOLD_CYCLES > 255) begin : g_bad_hold
    $error("HOLD_CYCLES out of range");
  end

  localparam logic [7:0] HOLD = 8'(HOLD_CYCLES);

  // state and counters
  rstctl_pkg::rst_state_t state;           // reset state manager
  rstctl_pkg::rst_state_t next_state;
  logic [7:0]             hold_cnt;        // remaining cycles of timed phase
  logic [7:0]             next_hold;
  logic [16:0]            pulse_cnt;       // remaining pin pulse cycles
  logic [16:0]            next_pulse;
  logic                   assert_cpu;      // cpu reset requested by state
  logic                   next_cpu;
  logic                   assert_per;      // peripheral reset requested by state
  logic                   next_per;
  logic                   pulse_start;     // reload pin pulse counter
  logic                   load_cause;      // cause update at release
  rstctl_pkg::cause_t     cause_val;
  rstctl_pkg::cause_t     last_cause;
  logic                   cmd_in_progress; // software command busy
  logic                   next_busy;

  // config fields
  logic                   pin_reset_enable;
  logic                   pin_event_irq_enable;
  logic [3:0]             pin_pulse_length;

  // pin synchronizer and edge state
  logic                   pin_meta;        // first stage, read by pin_sync only
  logic                   pin_sync;        // synchronized pin level
  logic                   pin_prev;        // previous synchronized level
  logic [1:0]             own_mask;        // trails pin_oe by the sync lag
  logic                   pin_fall_seen;
  logic                   next_fall;

  // decode pulse length into a cycle count
  function automatic logic [16:0] pulse_cycles(input logic [3:0] len);
    pulse_cycles = 17'h00001 << (5'(len) + 5'h01);
  endfunction : pulse_cycles

  // bus decode
  wire        bus_req    = avs_read | avs_write;
  wire        full_word  = (avs_byteenable == 4'hf);
  wire        key_ok     = (avs_writedata[`RC_KEY_MSB:`RC_KEY_LSB] == `RC_KEY_VALUE);
  wire        wr_fire    = avs_write & ~avs_waitrequest & full_word & key_ok;
  wire        hit_cmd    = (avs_address == `RC_OFF_COMMAND);
  wire        hit_status = (avs_address == `RC_OFF_STATUS);
  wire        hit_cfg    = (avs_address == `RC_OFF_CONFIG);
  wire        rd_take    = avs_read & avs_waitrequest & hit_status;
  wire        cfg_write  = wr_fire & hit_cfg;
  wire [2:0]  cmd_bits   = {avs_writedata[`RC_CMD_PIN_BIT], avs_writedata[`RC_CMD_PER_BIT],
                            avs_writedata[`RC_CMD_CPU_BIT]};
  // command writes while busy have no effect at all; config writes still land
  wire        cmd_fire   = wr_fire & hit_cmd & (|cmd_bits) & ~cmd_in_progress;

  // status and config read images; key field reads as zero
  wire [31:0] status_word = (32'(pin_fall_seen) << `RC_ST_FALL_BIT)
                          | (32'(last_cause) << `RC_ST_CAUSE_LSB)
                          | (32'(pin_sync) << `RC_ST_LEVEL_BIT)
                          | (32'(cmd_in_progress) << `RC_ST_BUSY_BIT);
  wire [31:0] config_word = (32'(pin_reset_enable) << `RC_CFG_RSTEN_BIT)
                          | (32'(pin_event_irq_enable) << `RC_CFG_IRQEN_BIT)
                          | (32'(pin_pulse_length) << `RC_CFG_LEN_LSB);
  // command register is write only; unmapped reads return zero
  wire [31:0] rd_mux      = hit_status ? status_word :
                            hit_cfg    ? config_word : 32'h00000000;

  // event decode
  wire wdog_hit  = wdog_fault & wdog_fault_reset_enable;
  wire own_pulse = pin_oe | own_mask[0] | own_mask[1];
  // irq enable diverts the pin event away from a reset
  wire user_low  = ~pin_sync & pin_reset_enable & ~pin_event_irq_enable
                 & ~own_pulse;
  wire pin_fell  = pin_prev & ~pin_sync;

  // one wait cycle per access, then the answer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // config survives every reset this block makes; only nrst clears it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_reset_enable     <= 1'b1;
      pin_event_irq_enable <= 1'b0;
      pin_pulse_length     <= 4'h0;
    end else if (cfg_write) begin
      pin_reset_enable     <= avs_writedata[`RC_CFG_RSTEN_BIT];
      pin_event_irq_enable <= avs_writedata[`RC_CFG_IRQEN_BIT];
      pin_pulse_length     <= avs_writedata[`RC_CFG_LEN_LSB +: 4];
    end
  end

  // two-flop synchronizer; only the second stage feeds logic
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      pin_prev <= 1'b1;
      own_mask <= 2'b11;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      own_mask <= {own_mask[0], pin_oe};
    end
  end

  // sticky fall flag: a fall in the read cycle wins over the clear
  assign next_fall = pin_fell | (pin_fall_seen & ~rd_take);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pin_fall_seen <= 1'b0;
      pin_irq       <= 1'b0;
    end else begin
      pin_fall_seen <= next_fall;
      pin_irq       <= next_fall & pin_event_irq_enable;
    end
  end

  // pin pulse counter; a restart reloads the full length
  assign next_pulse = pulse_start        ? pulse_cycles(pin_pulse_length) :
                      (pulse_cnt != '0)  ? pulse_cnt - 17'h00001 : pulse_cnt;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pulse_cnt <= `RC_GEN_PULSE;
      pin_oe    <= 1'b1;
      pin_out   <= 1'b0;
    end else begin
      pulse_cnt <= next_pulse;
      pin_oe    <= (next_pulse != '0);
      pin_out   <= 1'b0;
    end
  end

  // reset state manager next-state logic
  always_comb begin
    next_state  = state;
    next_hold   = hold_cnt;
    next_cpu    = assert_cpu;
    next_per    = assert_per;
    next_busy   = cmd_in_progress;
    pulse_start = 1'b0;
    load_cause  = 1'b0;
    cause_val   = last_cause;
    case (state)
      // supply reset tail: hold cpu until the power-up pulse ends
      rstctl_pkg::ST_GENERAL: begin
        if (!pin_oe) begin
          next_state = rstctl_pkg::ST_RUN;
          next_cpu   = 1'b0;
          next_per   = 1'b0;
          load_cause = 1'b1;
          cause_val  = `RC_CAUSE_GENERAL;
        end
      end
      // watchdog beats software beats pin
      rstctl_pkg::ST_RUN: begin
        if (wdog_hit) begin
          next_state  = rstctl_pkg::ST_WDOG;
          next_hold   = HOLD;
          next_cpu    = 1'b1;
          next_per    = ~wdog_cpu_only;
          pulse_start = ~wdog_cpu_only;
        end else if (cmd_fire) begin
          next_state  = rstctl_pkg::ST_SOFT;
          next_hold   = HOLD;
          next_cpu    = cmd_bits[0];
          next_per    = cmd_bits[1];
          pulse_start = cmd_bits[2];
          next_busy   = 1'b1;
        end else if (user_low) begin
          next_state  = rstctl_pkg::ST_USER;
          next_hold   = HOLD;
          next_cpu    = 1'b1;
          next_per    = 1'b1;
          pulse_start = 1'b1;
        end
      end
      // software reset: watchdog may take over, pin is ignored
      rstctl_pkg::ST_SOFT: begin
        if (wdog_hit) begin
          next_state  = rstctl_pkg::ST_WDOG;
          next_hold   = HOLD;
          next_cpu    = 1'b1;
          next_per    = ~wdog_cpu_only;
          pulse_start = ~wdog_cpu_only;
          next_busy   = 1'b0;
        end else if (hold_cnt == 8'h01) begin
          next_state = rstctl_pkg::ST_RUN;
          next_cpu   = 1'b0;
          next_per   = 1'b0;
          next_busy  = 1'b0;
          load_cause = assert_cpu;
          cause_val  = `RC_CAUSE_SOFT;
        end else begin
          next_hold = hold_cnt - 8'h01;
        end
      end
      // watchdog reset: nothing preempts it
      rstctl_pkg::ST_WDOG: begin
        if (hold_cnt == 8'h01) begin
          next_state = rstctl_pkg::ST_RUN;
          next_cpu   = 1'b0;
          next_per   = 1'b0;
          load_cause = 1'b1;
          cause_val  = `RC_CAUSE_WDOG;
        end else begin
          next_hold = hold_cnt - 8'h01;
        end
      end
      // user reset: startup count restarts while the pin is low
      rstctl_pkg::ST_USER: begin
        if (!pin_sync || pin_oe) begin
          next_hold = HOLD;
        end else if (hold_cnt == 8'h01) begin
          next_state = rstctl_pkg::ST_RUN;
          next_cpu   = 1'b0;
          next_per   = 1'b0;
          load_cause = 1'b1;
          cause_val  = `RC_CAUSE_USER;
        end else begin
          next_hold = hold_cnt - 8'h01;
        end
      end
      default: begin
        next_state = rstctl_pkg::ST_RUN;
        next_cpu   = 1'b0;
        next_per   = 1'b0;
      end
    endcase
  end

  // state registers; outputs come from flops of the next request
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state           <= rstctl_pkg::ST_GENERAL;
      hold_cnt        <= 8'h00;
      assert_cpu      <= 1'b1;
      assert_per      <= 1'b1;
      cmd_in_progress <= 1'b0;
      last_cause      <= `RC_CAUSE_GENERAL;
      proc_nrst       <= 1'b0;
      periph_nrst     <= 1'b0;
    end else begin
      state           <= next_state;
      hold_cnt        <= next_hold;
      assert_cpu      <= next_cpu;
      assert_per      <= next_per;
      cmd_in_progress <= next_busy;
      if (load_cause) begin
        last_cause <= cause_val;
      end
      proc_nrst       <= ~next_cpu;
      periph_nrst     <= ~next_per;
    end
  end

  // helper: measure each pin pulse against its programmed length
  logic [16:0] oe_len;
  logic [16:0] oe_want;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      oe_len  <= 17'h00000;  // the power-up pulse is counted from release
      oe_want <= `RC_GEN_PULSE;
    end else if (pulse_start) begin
      oe_len  <= 17'h00000;
      oe_want <= pulse_cycles(pin_pulse_length);
    end else if (pin_oe) begin
      oe_len  <= oe_len + 17'h00001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_pulse_length: assert property ($fell(pin_oe) |-> oe_len == oe_want)
    else $error("pin pulse length wrong");
  a_wdog_three: assert property ((state == rstctl_pkg::ST_RUN && wdog_hit) |=>
    !proc_nrst [*3] ##1 proc_nrst)
    else $error("watchdog reset not three cycles");
  a_wdog_ignored: assert property ((state == rstctl_pkg::ST_RUN && wdog_fault
    && !wdog_fault_reset_enable && !cmd_fire && !user_low) |=> proc_nrst)
    else $error("disabled watchdog fault caused reset");
  a_wdog_cpu_only: assert property ((state == rstctl_pkg::ST_RUN && wdog_hit
    && wdog_cpu_only) |=> !proc_nrst && periph_nrst)
    else $error("cpu-only watchdog reset hit peripherals");
  a_soft_hold: assert property ((state == rstctl_pkg::ST_RUN && cmd_fire
    && !wdog_hit && cmd_bits[0]) |=> !proc_nrst [*3])
    else $error("software cpu reset shorter than three cycles");
  a_cause_stable: assert property (!$rose(proc_nrst) |-> $stable(last_cause))
    else $error("cause changed outside cpu release");
  a_user_cause: assert property (($rose(proc_nrst)
    && $past(state) == rstctl_pkg::ST_USER) |-> last_cause == `RC_CAUSE_USER)
    else $error("user reset cause not loaded");
  a_busy_soft: assert property (cmd_in_progress |-> state == rstctl_pkg::ST_SOFT)
    else $error("busy flag outside software reset");
  a_user_pin_low: assert property ((state == rstctl_pkg::ST_USER && !pin_sync)
    |=> !proc_nrst && !periph_nrst)
    else $error("internal reset released while pin low");
  a_bad_key: assert property ((avs_write && !avs_waitrequest && !key_ok)
    |=> $stable(pin_pulse_length) && $stable(pin_reset_enable))
    else $error("config written with wrong key");

  c_wdog_reset: cover property (state == rstctl_pkg::ST_WDOG ##1 state == rstctl_pkg::ST_RUN);
  c_soft_reset: cover property (cmd_fire ##1 cmd_in_progress);
  c_user_reset: cover property (state == rstctl_pkg::ST_USER ##[1:20] proc_nrst);
  c_pin_irq:    cover property ($rose(pin_irq));

endmodule : system_reset_controller

// ===== test/board_reset_partner.sv
// another board device sharing the open-drain reset line
module board_reset_partner (
  // board side
  input  wire logic core_clk,
  input  wire logic pin_oe,
  input  wire logic pin_out,
  output logic      pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ext_low = 1'b0;  // this device pulling the line down

  // pull-up wins only when nobody pulls the line low
  assign pin_level = ((pin_oe && !pin_out) || ext_low) ? 1'b0 : 1'b1;

  // hold the line low for n cycles; changes land just after an edge
  task automatic hold(input int n);
    @(posedge core_clk);
    ext_low <= 1'b1;
    repeat (n) @(posedge core_clk);
    ext_low <= 1'b0;
  endtask : hold
endmodule : board_reset_partner

// ===== test/system_reset_controller_tb.sv
`include "rstctl_regs.svh"

module system_reset_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, supply reset and bus master drive
  logic        core_clk       = 1'b0;
  logic        nrst           = 1'b0;
  logic [3:0]  avs_address    = 4'h0;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  // watchdog side levels
  logic        wdog_fault              = 1'b0;
  logic        wdog_fault_reset_enable = 1'b0;
  logic        wdog_cpu_only           = 1'b0;
  // reset outputs and pin
  logic        proc_nrst, periph_nrst, pin_in, pin_out, pin_oe, pin_irq;
  // pulse monitors: running length, last length, pulse count
  int          oe_run, oe_len, oe_num, pl_run, pl_len, pl_num, pe_run, pe_len, pe_num;
  int          irq_cnt, cyc, n0, n1;
  int          miscompares = 0;
  int          check_count = 0;
  logic [31:0] rd;  // last read word

  system_reset_controller i_dut (
    .core_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .wdog_fault,
    .wdog_fault_reset_enable, .wdog_cpu_only, .proc_nrst, .periph_nrst,
    .pin_in, .pin_out, .pin_oe, .pin_irq
  );
  board_reset_partner i_part (.core_clk, .pin_oe, .pin_out, .pin_level(pin_in));

  // 100 mhz clock
  always #5 core_clk = ~core_clk;

  // supply reset pulses are not counted, only what follows release
  function automatic void track(input logic on, ref int run, ref int len, ref int num);
    if (nrst !== 1'b1) run = 0;
    else if (on === 1'b1) run++;
    else if (run > 0) begin
      len = run;
      num++;
      run = 0;
    end
  endfunction : track

  // sample pre-edge values, so lengths are in whole cycles
  always @(posedge core_clk) begin
    track(pin_oe, oe_run, oe_len, oe_num);
    track(!proc_nrst, pl_run, pl_len, pl_num);
    track(!periph_nrst, pe_run, pe_len, pe_num);
    if (pin_irq === 1'b1) irq_cnt++;
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  // one avalon transfer; waits for the slave, the timeout ends a hang
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // keyed write word
  function automatic logic [31:0] kw(input logic [23:0] v);
    kw = {`RC_KEY_VALUE, v};
  endfunction : kw

  // expected status word, busy clear
  function automatic logic [31:0] st(input logic f, input logic [2:0] c, input logic l);
    st = 32'(f) << `RC_ST_FALL_BIT | 32'(c) << `RC_ST_CAUSE_LSB | 32'(l) << `RC_ST_LEVEL_BIT;
  endfunction : st

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask : do_reset

  // watchdog fault for one cycle, then let the reset run out
  task automatic fault();
    @(posedge core_clk);
    wdog_fault <= 1'b1;
    @(posedge core_clk);
    wdog_fault <= 1'b0;
    repeat (20) @(posedge core_clk);
  endtask : fault

  // power-up: default length gives a two cycle pin pulse
  task automatic t_general();
    do_reset();
    chk("pin pulse", 2, oe_len);
    chk("cpu hold", 3, pl_len);
    chk("pin drive", 0, pin_out);
    bus(1'b0, `RC_OFF_STATUS, 0);
    chk("status", st(1, `RC_CAUSE_GENERAL, 1), rd);
    bus(1'b0, `RC_OFF_CONFIG, 0);
    chk("config", `RC_CFG_RESET, rd);
    bus(1'b0, 4'hc, 0);
    chk("unmapped", 0, rd);
    $display("test general done");
  endtask : t_general

  // cpu+peripheral command, second command while busy is dropped
  task automatic t_soft();
    n0 = oe_num;
    bus(1'b1, `RC_OFF_COMMAND, kw(24'h000005));
    bus(1'b1, `RC_OFF_COMMAND, kw(24'h000008));
    repeat (10) @(posedge core_clk);
    chk("cpu hold", 3, pl_len);
    chk("periph hold", 3, pe_len);
    chk("pin pulses", n0, oe_num);
    bus(1'b0, `RC_OFF_STATUS, 0);
    chk("status", st(0, `RC_CAUSE_SOFT, 1), rd);
    $display("test soft done");
  endtask : t_soft

  // key guard, then pin-only command with length 1
  task automatic t_config();
    bus(1'b1, `RC_OFF_CONFIG, 32'h5a000301);
    bus(1'b0, `RC_OFF_CONFIG, 0);
    chk("bad key", `RC_CFG_RESET, rd);
    bus(1'b1, `RC_OFF_CONFIG, kw(24'h000101));
    bus(1'b0, `RC_OFF_CONFIG, 0);
    chk("config", 32'h00000101, rd);
    // partial byte enables must leave the config untouched
    avs_byteenable <= 4'h1;
    bus(1'b1, `RC_OFF_CONFIG, kw(24'h000301));
    avs_byteenable <= 4'hf;
    bus(1'b0, `RC_OFF_CONFIG, 0);
    chk("partial write", 32'h00000101, rd);
    n0 = pl_num;
    bus(1'b1, `RC_OFF_COMMAND, kw(24'h000008));
    // read straight after the command lands inside the busy window
    bus(1'b0, `RC_OFF_STATUS, 0);
    chk("busy", st(0, `RC_CAUSE_SOFT, 1) | (32'h1 << `RC_ST_BUSY_BIT), rd);
    repeat (20) @(posedge core_clk);
    chk("pin pulse", 4, oe_len);
    chk("cpu pulses", n0, pl_num);
    bus(1'b0, `RC_OFF_STATUS, 0);
    chk("status", st(1, `RC_CAUSE_SOFT, 1), rd);
    $display("test config done");
  endtask : t_config

  // watchdog disabled, full and cpu-only
  task automatic t_wdog();
    n0 = pl_num;
    fault();
    chk("cpu pulses", n0, pl_num);
    wdog_fault_reset_enable <= 1'b1;
    n1 = pe_num;
    fault();
    chk("cpu hold", 3, pl_len);
    chk("periph pulses", n1 + 1, pe_num);
    chk("pin pulse", 4, oe_len);
    bus(1'b0, `RC_OFF_STATUS, 0);
    chk("status", st(1, `RC_CAUSE_WDOG, 1), rd);
    bus(1'b0, `RC_OFF_CONFIG, 0);
    chk("config kept", 32'h00000101, rd);
    wdog_cpu_only <= 1'b1;
    n0 = pe_num;
    n1 = oe_num;
    fault();
    chk("cpu hold", 3, pl_len);
    chk("periph pulses", n0, pe_num);
    chk("pin pulses", n1, oe_num);
    $display("test wdog done");
  endtask : t_wdog

  // board device holds the line well past the own pulse
  task automatic t_user();
    n0 = pl_num;
    fork
      i_part.hold(40);
      begin
        repeat (20) @(posedge core_clk);
        bus(1'b0, `RC_OFF_STATUS, 0);
        chk("status held", st(1, `RC_CAUSE_WDOG, 0), rd);
      end
    join
    repeat (20) @(posedge core_clk);
    chk("cpu pulses", n0 + 1, pl_num);
    chk("cpu held", 1, pl_len >= 40);
    chk("periph held", 1, pe_len >= 40);
    bus(1'b0, `RC_OFF_STATUS, 0);
    chk("status", st(0, `RC_CAUSE_USER, 1), rd);
    $display("test user done");
  endtask : t_user

  // pin event as interrupt, cleared by status read
  task automatic t_irq();
    bus(1'b1, `RC_OFF_CONFIG, kw(24'h000110));
    n0 = pl_num;
    irq_cnt = 0;
    i_part.hold(10);
    repeat (10) @(posedge core_clk);
    chk("irq seen", 1, irq_cnt > 0);
    chk("cpu pulses", n0, pl_num);
    bus(1'b0, `RC_OFF_STATUS, 0);
    chk("status", st(1, `RC_CAUSE_USER, 1), rd);
    repeat (2) @(posedge core_clk);
    irq_cnt = 0;
    repeat (5) @(posedge core_clk);
    chk("irq cleared", 0, irq_cnt);
    $display("test irq done");
  endtask : t_irq

  // watchdog fault in mid software reset takes over
  task automatic t_prio();
    bus(1'b1, `RC_OFF_COMMAND, kw(24'h000001));
    wdog_fault <= 1'b1;
    @(posedge core_clk);
    wdog_fault <= 1'b0;
    repeat (20) @(posedge core_clk);
    bus(1'b0, `RC_OFF_STATUS, 0);
    chk("status", st(0, `RC_CAUSE_WDOG, 1), rd);
    $display("test prio done");
  endtask : t_prio

  // second supply reset clears the length field again
  task automatic t_rerun();
    do_reset();
    chk("pin pulse", 2, oe_len);
    bus(1'b0, `RC_OFF_CONFIG, 0);
    chk("config", `RC_CFG_RESET, rd);
    $display("test rerun done");
  endtask : t_rerun

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    t_general();
    t_soft();
    t_config();
    t_wdog();
    t_user();
    t_irq();
    t_prio();
    t_rerun();
    wrap_up();
  end
endmodule : system_reset_controller_tb
